/* File: hw/ftrc_pkg.sv */
// constants, types and reset values for the flow totalizer remote control
// assumes a single 10 MHz system clock and a synchronous reset
package ftrc_pkg;
   // width of each direction's totalizer count
   localparam int FTRC_CNT_W = 32;
   // count value after a clear
   localparam logic [FTRC_CNT_W-1:0] FTRC_CNT_ZERO = 32'h0000_0000;
   // one count step per accepted flow pulse
   localparam logic [FTRC_CNT_W-1:0] FTRC_CNT_STEP = 32'h0000_0001;
   // polarity after configuration reset: 0 means active high
   localparam logic FTRC_POL_RST = 1'h0;

   // role given to the remote control input
   typedef enum logic [0:0] {
      FTRC_ROLE_START_STOP = 1'h0,
      FTRC_ROLE_RESET_START = 1'h1
   } ftrc_role_type;

   // whole state of the top module
   typedef struct packed {
      logic [FTRC_CNT_W-1:0] fwd;
      logic [FTRC_CNT_W-1:0] rev;
      logic [FTRC_CNT_W-1:0] shown;
      logic pulse;
      logic nv_store;
      logic active_low;
      ftrc_role_type role;
   } ftrc_state_type;

   // state of the input synchroniser
   typedef struct packed {
      logic meta;
      logic sync;
   } ftrc_sync_type;

   localparam ftrc_state_type FTRC_STATE_RST = '{
      fwd: FTRC_CNT_ZERO, rev: FTRC_CNT_ZERO, shown: FTRC_CNT_ZERO,
      pulse: 1'h0, nv_store: 1'h0, active_low: FTRC_POL_RST,
      role: FTRC_ROLE_START_STOP};
   localparam ftrc_sync_type FTRC_SYNC_RST = '{meta: 1'h0, sync: 1'h0};
endpackage

/* File: hw/ftrc_sync.sv */
// two-stage synchroniser for the remote control input
// assumes the raw level may change at any time relative to sys_clk
`timescale 1ns/1ns
`default_nettype none
module ftrc_sync (
   input wire logic sys_clk,
   input wire logic reset,
   ftrc_sync_if.sync port_if
);
   ftrc_pkg::ftrc_sync_type st_reg;
   ftrc_pkg::ftrc_sync_type st_next;

   // first stage feeds only the second stage
   // two flop chain
   always_comb begin
      st_next = st_reg;
      st_next.meta = port_if.raw;
      st_next.sync = st_reg.meta;
   end

   // state register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_reg <= ftrc_pkg::FTRC_SYNC_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   assign port_if.synced = st_reg.sync;

   sequence seq_raw_high2;
      port_if.raw ##1 port_if.raw;
   endsequence

   AST_SYNC_DELAY: assert property (
      @(posedge sys_clk) disable iff (reset)
      seq_raw_high2 |=> port_if.synced)
      else $error("synced level lags raw by more than two cycles");
endmodule // ftrc_sync
`default_nettype wire

/* File: hw/ftrc_sync_if.sv */
// carrier between the totalizer top and its input synchroniser
// assumes both ends run on sys_clk
`timescale 1ns/1ns
`default_nettype none
interface ftrc_sync_if;
   logic raw;
   logic synced;
   modport top (output raw, input synced);
   modport sync (input raw, output synced);
endinterface
`default_nettype wire

/* File: hw/ftrc_top.sv */
// flow totalizer with remote start/stop or reset/start control
// assumes flow pulses and direction come synchronous to sys_clk and that
// external non-volatile storage saves nv counts on nv_store_out
// Summary of operation
// - bidirectional mode shows forward count forward, reverse count reverse
// - a totalizer reset clears forward and reverse counts together
// - counts are kept in non-volatile storage and restored after power loss
// - start/stop, active high: low halts counting and pulses, high runs
// - reset/start, active high: high clears and holds, low runs
// - control polarity is active high after configuration reset
// - active low polarity inverts the input sense for both roles
`timescale 1ns/1ns
`default_nettype none
module ftrc_top (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic remote_control_input,
   input wire logic flow_pulse,
   input wire logic flow_reverse,
   input wire logic bidir_mode,
   input wire logic clear_request,
   input wire logic cfg_write,
   input wire logic cfg_active_low,
   input wire logic cfg_reset_start,
   input wire logic nv_load,
   input wire logic [ftrc_pkg::FTRC_CNT_W-1:0] nv_fwd_in,
   input wire logic [ftrc_pkg::FTRC_CNT_W-1:0] nv_rev_in,
   output logic [ftrc_pkg::FTRC_CNT_W-1:0] fwd_count,
   output logic [ftrc_pkg::FTRC_CNT_W-1:0] rev_count,
   output logic [ftrc_pkg::FTRC_CNT_W-1:0] shown_count,
   output logic scaled_pulse_out,
   output logic nv_store_out,
   output logic cfg_active_low_out,
   output logic cfg_reset_start_out
);
   ftrc_pkg::ftrc_state_type st_reg;
   ftrc_pkg::ftrc_state_type st_next;
   ftrc_sync_if sync_if ();
   logic ctl_asserted;
   logic run_enable;
   logic hold_clear;

   // raw pin goes through the synchroniser
   assign sync_if.raw = remote_control_input;

   ftrc_sync u_sync (
      .sys_clk(sys_clk),
      .reset(reset),
      .port_if(sync_if)
   );

   // selects what the display shows
   function automatic logic [ftrc_pkg::FTRC_CNT_W-1:0] pick_shown(
      input logic bidir,
      input logic reverse,
      input logic [ftrc_pkg::FTRC_CNT_W-1:0] fwd,
      input logic [ftrc_pkg::FTRC_CNT_W-1:0] rev);
      pick_shown = (bidir && reverse) ? rev : fwd;
   endfunction

   // control level decode for both roles
   always_comb begin
      ctl_asserted = sync_if.synced ^ st_reg.active_low;
      run_enable = (st_reg.role == ftrc_pkg::FTRC_ROLE_START_STOP) ?
                   ctl_asserted : ~ctl_asserted;
      hold_clear = (st_reg.role == ftrc_pkg::FTRC_ROLE_RESET_START) &&
                   ctl_asserted;
   end

   // next-state logic: counting, clearing, restore and display
   always_comb begin
      st_next = st_reg;
      st_next.pulse = 1'h0;
      st_next.nv_store = 1'h0;
      if (cfg_write) begin
         st_next.active_low = cfg_active_low;
         st_next.role = cfg_reset_start ? ftrc_pkg::FTRC_ROLE_RESET_START :
                        ftrc_pkg::FTRC_ROLE_START_STOP;
      end
      if (nv_load) begin
         st_next.fwd = nv_fwd_in;
         st_next.rev = nv_rev_in;
      end else if (clear_request || hold_clear) begin
         st_next.fwd = ftrc_pkg::FTRC_CNT_ZERO;
         st_next.rev = ftrc_pkg::FTRC_CNT_ZERO;
         st_next.nv_store = 1'h1;
      end else if (flow_pulse && run_enable) begin
         if (flow_reverse) begin
            st_next.rev = st_reg.rev + ftrc_pkg::FTRC_CNT_STEP;
         end else begin
            st_next.fwd = st_reg.fwd + ftrc_pkg::FTRC_CNT_STEP;
         end
         st_next.pulse = 1'h1;
         st_next.nv_store = 1'h1;
      end
      st_next.shown = pick_shown(bidir_mode, flow_reverse,
                                 st_reg.fwd, st_reg.rev);
   end

   // state register
   // polarity reset value
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         st_reg <= ftrc_pkg::FTRC_STATE_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state flops
   assign fwd_count = st_reg.fwd;
   assign rev_count = st_reg.rev;
   assign shown_count = st_reg.shown;
   assign scaled_pulse_out = st_reg.pulse;
   assign nv_store_out = st_reg.nv_store;
   assign cfg_active_low_out = st_reg.active_low;
   assign cfg_reset_start_out = st_reg.role;

   sequence seq_quiet;
      !nv_load && !clear_request && !cfg_write;
   endsequence

   sequence seq_ss_run_fwd;
      seq_quiet and (st_reg.role == ftrc_pkg::FTRC_ROLE_START_STOP &&
      ctl_asserted && flow_pulse && !flow_reverse);
   endsequence

   sequence seq_ss_halt;
      seq_quiet and (st_reg.role == ftrc_pkg::FTRC_ROLE_START_STOP &&
      !ctl_asserted);
   endsequence

   // reset/start released by its pin: a flow pulse counts
   sequence seq_rs_run;
      seq_quiet and (st_reg.role == ftrc_pkg::FTRC_ROLE_RESET_START &&
      !ctl_asserted && flow_pulse);
   endsequence

   // active low start/stop with the pin high: totalizer halted
   sequence seq_ss_inv_halt;
      seq_quiet and (st_reg.role == ftrc_pkg::FTRC_ROLE_START_STOP &&
      st_reg.active_low && sync_if.synced);
   endsequence

   AST_SHOW_REV: assert property (
      @(posedge sys_clk) disable iff (reset)
      bidir_mode && flow_reverse |=> shown_count == $past(st_reg.rev))
      else $error("reverse count not shown in reverse range");

   AST_SHOW_FWD: assert property (
      @(posedge sys_clk) disable iff (reset)
      !flow_reverse |=> shown_count == $past(st_reg.fwd))
      else $error("forward count not shown in forward range");

   AST_CLEAR_BOTH: assert property (
      @(posedge sys_clk) disable iff (reset)
      clear_request && !nv_load |=> fwd_count == ftrc_pkg::FTRC_CNT_ZERO &&
      rev_count == ftrc_pkg::FTRC_CNT_ZERO && nv_store_out)
      else $error("clear did not zero both counts");

   AST_NV_RESTORE: assert property (
      @(posedge sys_clk) disable iff (reset)
      nv_load |=> fwd_count == $past(nv_fwd_in) &&
      rev_count == $past(nv_rev_in))
      else $error("restored counts differ from storage");

   AST_SS_RUN: assert property (
      @(posedge sys_clk) disable iff (reset)
      seq_ss_run_fwd |=> fwd_count == $past(fwd_count) +
      ftrc_pkg::FTRC_CNT_STEP && scaled_pulse_out)
      else $error("running start/stop did not count");

   AST_SS_HALT: assert property (
      @(posedge sys_clk) disable iff (reset)
      seq_ss_halt |=> $stable(fwd_count) && $stable(rev_count) &&
      !scaled_pulse_out)
      else $error("halted start/stop still counted");

   AST_RS_CLEAR: assert property (
      @(posedge sys_clk) disable iff (reset)
      !nv_load && st_reg.role == ftrc_pkg::FTRC_ROLE_RESET_START &&
      ctl_asserted |=> fwd_count == ftrc_pkg::FTRC_CNT_ZERO &&
      rev_count == ftrc_pkg::FTRC_CNT_ZERO && !scaled_pulse_out)
      else $error("reset/start did not clear and hold");

   AST_POL_DEFAULT: assert property (
      @(posedge sys_clk)
      reset |=> !cfg_active_low_out)
      else $error("polarity not active high after reset");

   AST_POL_INVERT: assert property (
      @(posedge sys_clk) disable iff (reset)
      !nv_load && st_reg.active_low && !sync_if.synced &&
      st_reg.role == ftrc_pkg::FTRC_ROLE_RESET_START
      |=> fwd_count == ftrc_pkg::FTRC_CNT_ZERO && !scaled_pulse_out)
      else $error("active low reset/start did not clear on low");

   AST_SHOW_UNI: assert property (
      @(posedge sys_clk) disable iff (reset)
      !bidir_mode |=> shown_count == $past(st_reg.fwd))
      else $error("unidirectional mode did not show forward count");

   AST_STORE_ON_COUNT: assert property (
      @(posedge sys_clk) disable iff (reset)
      scaled_pulse_out |-> nv_store_out)
      else $error("counted pulse not handed to storage");

   AST_RS_RUN: assert property (
      @(posedge sys_clk) disable iff (reset)
      seq_rs_run |=> scaled_pulse_out)
      else $error("released reset/start did not count");

   AST_SS_INV_HALT: assert property (
      @(posedge sys_clk) disable iff (reset)
      seq_ss_inv_halt |=> $stable(fwd_count) && $stable(rev_count) &&
      !scaled_pulse_out)
      else $error("active low start/stop counted with pin high");
endmodule // ftrc_top
`default_nettype wire

/* File: tb/ftrc_bench.sv */
// self-checking bench for the flow totalizer remote control
// assumes ftrc_pkg, ftrc_sync_if, ftrc_sync and ftrc_top compiled first
`timescale 1ns/1ns
`default_nettype none
module ftrc_bench;
   localparam int W = ftrc_pkg::FTRC_CNT_W;
   logic sys_clk, reset, level, slow, rci, flow_pulse, flow_reverse;
   logic bidir_mode, clear_request, cfg_write, cfg_active_low;
   logic cfg_reset_start, nv_load, scaled_pulse_out, nv_store_out;
   logic cfg_active_low_out, cfg_reset_start_out;
   logic [W-1:0] nv_fwd_in, nv_rev_in, fwd_count, rev_count, shown_count;
   logic [W-1:0] ef, er;
   logic [2*W-1:0] notes[$];
   logic [2*W-1:0] nt;
   logic [31:0] seed;
   int failures, checked;
   ftrc_contact u_ftrc_contact (.level(level), .slow(slow), .contact(rci));
   ftrc_top u_ftrc_top (.sys_clk(sys_clk), .reset(reset),
      .remote_control_input(rci), .flow_pulse(flow_pulse),
      .flow_reverse(flow_reverse), .bidir_mode(bidir_mode),
      .clear_request(clear_request), .cfg_write(cfg_write),
      .cfg_active_low(cfg_active_low), .cfg_reset_start(cfg_reset_start),
      .nv_load(nv_load), .nv_fwd_in(nv_fwd_in), .nv_rev_in(nv_rev_in),
      .fwd_count(fwd_count), .rev_count(rev_count),
      .shown_count(shown_count), .scaled_pulse_out(scaled_pulse_out),
      .nv_store_out(nv_store_out), .cfg_active_low_out(cfg_active_low_out),
      .cfg_reset_start_out(cfg_reset_start_out));
   // clock generator, 100 ns period
   initial begin
      sys_clk = 1'h0;
      forever #50 sys_clk = ~sys_clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic check(input string what, input logic [63:0] seen,
                        input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // one flow pulse; a counted one leaves a note for the watcher
   task automatic pulse(input logic dir, input logic run);
      flow_reverse = dir;
      flow_pulse = 1'h1;
      if (run) begin
         if (dir) er = er + 1;
         else ef = ef + 1;
         notes.push_back({ef, er});
      end
      @(negedge sys_clk);
      flow_pulse = 1'h0;
      @(negedge sys_clk);
      check("counts", {fwd_count, rev_count}, {ef, er});
   endtask
   // load configuration and move the contact, then let it settle
   task automatic setup(input logic al, input logic rs, input logic lv);
      cfg_active_low = al;
      cfg_reset_start = rs;
      cfg_write = 1'h1;
      level = lv;
      @(negedge sys_clk);
      cfg_write = 1'h0;
      repeat (6) @(negedge sys_clk);
      check("cfg_active_low_out", cfg_active_low_out, al);
      check("cfg_reset_start_out", cfg_reset_start_out, rs);
   endtask
   // each scaled pulse must match the oldest noted count pair
   always @(negedge sys_clk) begin
      if (scaled_pulse_out === 1'h1) begin
         if (notes.size() == 0) begin
            check("scaled_pulse_out", 1, 0);
         end else begin
            nt = notes.pop_front();
            check("pulse counts", {fwd_count, rev_count}, nt);
         end
         check("nv_store_out", nv_store_out, 1);
      end
   end
   initial begin
      repeat (5000) @(negedge sys_clk);
      check("timeout", 1, 0);
      conclude();
   end
   initial begin
      {reset, level, slow, flow_pulse, flow_reverse, bidir_mode} = 6'h29;
      {clear_request, cfg_write, cfg_active_low, cfg_reset_start} = 4'h0;
      {nv_load, nv_fwd_in, nv_rev_in, ef, er} = '0;
      seed = 32'h0001_80b2;
      failures = 0;
      checked = 0;
      repeat (6) @(negedge sys_clk);
      reset = 1'h0;
      @(negedge sys_clk);
      check("polarity", cfg_active_low_out, 0);
      // high runs, low halts; bounce settles
      setup(1'h0, 1'h0, 1'h1);
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         pulse(seed[3], 1'h1);
      end
      level = 1'h0;
      repeat (6) @(negedge sys_clk);
      pulse(1'h0, 1'h0);
      pulse(1'h1, 1'h0);
      nv_fwd_in = xs(seed);
      nv_rev_in = xs(nv_fwd_in);
      nv_load = 1'h1;
      @(negedge sys_clk);
      nv_load = 1'h0;
      {ef, er} = {nv_fwd_in, nv_rev_in};
      @(negedge sys_clk);
      check("restored", {fwd_count, rev_count}, {ef, er});
      flow_reverse = 1'h1;
      repeat (3) @(negedge sys_clk);
      check("shown rev", shown_count, er);
      bidir_mode = 1'h0;
      repeat (3) @(negedge sys_clk);
      check("shown uni", shown_count, ef);
      bidir_mode = 1'h1;
      flow_reverse = 1'h0;
      repeat (3) @(negedge sys_clk);
      check("shown fwd", shown_count, ef);
      setup(1'h0, 1'h1, 1'h1);
      {ef, er} = '0;
      pulse(1'h0, 1'h0);
      level = 1'h0;
      repeat (6) @(negedge sys_clk);
      pulse(1'h1, 1'h1);
      pulse(1'h0, 1'h1);
      clear_request = 1'h1;
      @(negedge sys_clk);
      clear_request = 1'h0;
      {ef, er} = '0;
      check("clear store", nv_store_out, 1);
      @(negedge sys_clk);
      check("cleared", {fwd_count, rev_count}, {ef, er});
      slow = 1'h0;
      setup(1'h1, 1'h0, 1'h0);
      pulse(1'h0, 1'h1);
      level = 1'h1;
      repeat (6) @(negedge sys_clk);
      pulse(1'h0, 1'h0);
      setup(1'h1, 1'h1, 1'h1);
      pulse(1'h1, 1'h1);
      level = 1'h0;
      repeat (6) @(negedge sys_clk);
      {ef, er} = '0;
      pulse(1'h1, 1'h0);
      for (int i = 0; i < 10 && notes.size() != 0; i++) @(negedge sys_clk);
      check("notes left", notes.size(), 0);
      reset = 1'h1;
      repeat (2) @(negedge sys_clk);
      reset = 1'h0;
      @(negedge sys_clk);
      check("polarity again", cfg_active_low_out, 0);
      check("role again", cfg_reset_start_out, 0);
      conclude();
   end
endmodule // ftrc_bench
`default_nettype wire

/* File: tb/ftrc_contact.sv */
// external contact model driving the remote control input
// assumes the bench sets the wanted level; slow mode bounces first
`timescale 1ns/1ns
`default_nettype none
module ftrc_contact (
   input wire logic level,
   input wire logic slow,
   output logic contact
);
   initial contact = 1'h0;
   // follow the wanted level, with sub-cycle bounce when slow
   always @(level) begin
      if (slow) begin
         repeat (3) begin
            #37 contact = ~level;
            #29 contact = level;
         end
      end else begin
         #13 contact = level;
      end
   end
endmodule // ftrc_contact
`default_nettype wire
